/* verilog/rbn_readback_nvm.v */
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "rbn_map.vh"

module rbn_readback_nvm #(
    parameter [18:0] REFRESH_CYC    = `RBN_REFRESH_CYC,
    parameter [27:0] SAVE_LIMIT_CYC = `RBN_SAVE_LIMIT_CYC
) (
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Measurement front ends
    input  wire        speed_strobe,
    input  wire [10:0] speed_count,
    input  wire        meas_current,
    input  wire [9:0]  current_count,
    input  wire [9:0]  supply_count,
    input  wire [9:0]  temp_count,
    input  wire        pwm_period_strobe,
    input  wire [9:0]  duty_count,
    input  wire [9:0]  advance_count,
    input  wire        pwm_demand_valid,
    input  wire [9:0]  pwm_demand,
    output wire [2:0]  speed_resolution_sel,
    output wire        advance_mode_sel,
    output wire [9:0]  demand_value_out,
    // Fault sources
    input  wire [8:0]  fault_in,
    input  wire [8:0]  diag_in,
    input  wire        serial_write_attempt,
    input  wire        prog_voltage_low,
    // Configuration register file
    output reg  [4:0]  cfg_addr,
    input  wire [9:0]  cfg_rd_data,
    output reg         cfg_wr_en,
    output reg  [9:0]  cfg_wr_data,
    // Non-volatile memory macro
    output reg         nvm_req,
    output reg         nvm_we,
    output reg  [4:0]  nvm_addr,
    output reg  [9:0]  nvm_wdata,
    input  wire        nvm_ack,
    input  wire        nvm_err,
    input  wire [9:0]  nvm_rdata,
    output wire        save_busy,
    output wire        load_busy,
    output wire [15:0] status_word
);

    localparam [3:0] ST_IDLE   = 4'b0001;
    localparam [3:0] ST_LOAD   = 4'b0010;
    localparam [3:0] ST_WRITE  = 4'b0100;
    localparam [3:0] ST_VERIFY = 4'b1000;
    function [4:0] next_addr;
        input [4:0] a;
        begin
            next_addr = (a == `RBN_NVM_GAP_BEFORE) ? `RBN_NVM_GAP_AFTER : a + 5'h01;
        end
    endfunction
    // The sleep request bit is never stored, so a reload cannot put the
    // part straight back to sleep; only the upper demand bits are kept.
    function [9:0] save_word;
        input [4:0] a;
        input [9:0] d;
        begin
            save_word = d;
            if (a == `RBN_NVM_SLEEP_REG)
                save_word[`RBN_NVM_SLEEP_BIT] = 1'b0;
            if (a == `RBN_NVM_DEMAND_REG)
                save_word = {d[9:2], 2'b00};
        end
    endfunction
    function parity_odd;
        input [14:0] v;
        begin
            parity_odd = ~(^v);
        end
    endfunction

    reg [7:0]  ctrl;
    reg [9:0]  demand_value;
    reg [1:0]  nvm_save_ctrl;
    reg [3:0]  state;
    reg [27:0] save_timer;
    reg [18:0] refresh_timer;
    reg [10:0] speed_hold;
    reg [9:0]  current_hold;
    reg [9:0]  supply_hold;
    reg [9:0]  temp_hold;
    reg [9:0]  duty_hold;
    reg [9:0]  advance_hold;
    reg [8:0]  fault_lat;
    reg [8:0]  diag_lat;
    reg        por_flag;
    reg        serial_error_flag;
    reg        prog_voltage_low_flag;
    reg [9:0]  sel_value;
    wire [2:0] readback_select  = ctrl[`RBN_CTRL_SEL_LSB +: 3];
    wire       keep_on_read_bit = ctrl[`RBN_CTRL_KEEP_BIT];
    wire       fault_summary_flag;
    wire       over_range_speed_bit;
    wire [9:0] diag_word;
    wire [15:0] readback_word;
    wire       setup    = psel & ~penable;
    wire       access   = psel & penable;
    wire       wr_acc   = access & pwrite;
    wire       rd_acc   = access & ~pwrite;
    wire       hit_ctrl = (paddr == `RBN_ADDR_CTRL);
    wire       hit_save = (paddr == `RBN_ADDR_SAVE);
    wire       hit_dem  = (paddr == `RBN_ADDR_DEMAND);
    wire       hit_rb   = (paddr == `RBN_ADDR_READBACK);
    wire       hit_st   = (paddr == `RBN_ADDR_STATUS);
    wire       mapped   = hit_ctrl | hit_save | hit_dem | hit_rb | hit_st;
    wire       ro_hit   = hit_rb | hit_st;
    wire       seq_busy = ~state[0];
    wire       wr_locked = wr_acc & mapped & ~ro_hit & seq_busy;
    wire       wr_ok    = wr_acc & mapped & ~ro_hit & ~seq_busy;
    wire       start_save = wr_ok & hit_save &
                            (nvm_save_ctrl == `RBN_SAV_ARMED) &
                            (pwdata[1:0] == `RBN_SAV_START);
    wire       write_rejected = (wr_acc | serial_write_attempt) & save_busy;
    wire       vpp_abort = prog_voltage_low & (state[2] | state[3]);
    wire       limit_abort = (state[2] | state[3]) & (save_timer == SAVE_LIMIT_CYC);
    wire       nvm_done = nvm_req & nvm_ack;
    wire       last_addr = (nvm_addr == `RBN_NVM_DEMAND_REG);
    wire       refresh_tick = (refresh_timer == REFRESH_CYC - 19'h00001);
    wire       clr_status = rd_acc & hit_st & ~keep_on_read_bit;
    wire       clr_diag = rd_acc & hit_rb & ~keep_on_read_bit &
                          (readback_select == `RBN_SEL_DIAG);
    wire [9:0] expect_word = save_word(nvm_addr, last_addr ? demand_value : cfg_rd_data);

    assign pready               = 1'b1;
    assign pslverr              = access & (~mapped | (pwrite & ro_hit) | wr_locked);
    assign speed_resolution_sel = ctrl[`RBN_CTRL_SRES_LSB +: 3];
    assign advance_mode_sel     = ctrl[`RBN_CTRL_AMODE_BIT];
    assign demand_value_out     = demand_value;
    assign save_busy            = state[2] | state[3];
    assign load_busy            = state[1];
    assign over_range_speed_bit = speed_hold[10];
    assign diag_word            = {over_range_speed_bit, diag_lat};
    assign fault_summary_flag   = por_flag | serial_error_flag |
                                  prog_voltage_low_flag | (|fault_lat);
    assign status_word          = {fault_summary_flag, por_flag, serial_error_flag, fault_lat,
                                   prog_voltage_low_flag, |diag_lat[2:0], |diag_lat[8:3], 1'b0};
    assign readback_word        = {status_word[15:11], sel_value,
                                   parity_odd({status_word[15:11], sel_value})};

    always @*
    begin
        case (readback_select)
            `RBN_SEL_DIAG:    sel_value = diag_word;
            `RBN_SEL_SPEED:   sel_value = speed_hold[9:0];
            `RBN_SEL_CURRENT: sel_value = current_hold;
            `RBN_SEL_SUPPLY:  sel_value = supply_hold;
            `RBN_SEL_TEMP:    sel_value = temp_hold;
            `RBN_SEL_DEMAND:  sel_value = demand_value;
            `RBN_SEL_DUTY:    sel_value = duty_hold;
            `RBN_SEL_ADVANCE: sel_value = advance_mode_sel ? advance_hold :
                                          {4'h0, advance_hold[5:0]};
            default:          sel_value = 10'h000;
        endcase
    end

    // Read data is latched in the setup phase so the zero-wait access
    // phase presents it straight from a flip-flop.
    wire [31:0] rd_word = hit_ctrl ? {24'h00_0000, ctrl} :
                          hit_save ? {29'h0000_0000, save_busy, nvm_save_ctrl} :
                          hit_dem  ? {22'h00_0000, demand_value} :
                          hit_rb   ? {16'h0000, readback_word} :
                          hit_st   ? {16'h0000, status_word} : 32'h0000_0000;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup & ~pwrite)
            prdata <= rd_word;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= `RBN_CTRL_RESET;
        else if (wr_ok & hit_ctrl)
            ctrl <= pwdata[7:0];
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            demand_value <= `RBN_DEMAND_RESET;
        else if (state[1] & nvm_done & (nvm_addr == `RBN_NVM_DEMAND_REG))
            demand_value <= nvm_rdata;
        else if (wr_ok & hit_dem)
            demand_value <= pwdata[9:0];
        else if (pwm_demand_valid & ~seq_busy)
            demand_value <= pwm_demand;
    end

    // Measurement holding registers. Each one changes only on its own
    // refresh event so a read never sees a half-updated value.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            refresh_timer <= 19'h0_0000;
            speed_hold    <= 11'h000;
            current_hold  <= 10'h000;
            supply_hold   <= 10'h000;
            temp_hold     <= 10'h000;
            duty_hold     <= 10'h000;
            advance_hold  <= 10'h000;
        end
        else
        begin
            refresh_timer <= refresh_tick ? 19'h0_0000 : refresh_timer + 19'h0_0001;
            if (speed_strobe)
                speed_hold <= speed_count;
            if (refresh_tick)
            begin
                current_hold <= meas_current ? current_count : 10'h000;
                supply_hold  <= supply_count;
                temp_hold    <= temp_count;
            end
            if (pwm_period_strobe)
            begin
                duty_hold    <= duty_count;
                advance_hold <= advance_count;
            end
        end
    end

    // Latched flags: a new event in the clearing cycle always survives,
    // and a fault still present is never cleared.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault_lat             <= 9'h000;
            diag_lat              <= 9'h000;
            por_flag              <= 1'b1;
            serial_error_flag     <= 1'b0;
            prog_voltage_low_flag <= 1'b0;
        end
        else
        begin
            fault_lat <= (clr_status ? (fault_lat & fault_in) : fault_lat) | fault_in;
            diag_lat  <= (clr_diag ? (diag_lat & diag_in) : diag_lat) | diag_in;
            por_flag <= por_flag & ~clr_status;
            serial_error_flag <= (clr_status ? 1'b0 : serial_error_flag) |
                                 write_rejected | (state[1] & nvm_done & nvm_err);
            prog_voltage_low_flag <= (clr_status ? (prog_voltage_low_flag &
                                      prog_voltage_low) : prog_voltage_low_flag) |
                                     vpp_abort;
        end
    end

    // Save and reload sequencer. One memory operation is outstanding at a
    // time; the request holds until the macro acknowledges it or a save aborts.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state         <= ST_LOAD;
            nvm_save_ctrl <= `RBN_SAVE_RESET;
            save_timer    <= 28'h000_0000;
            nvm_req       <= 1'b1;
            nvm_we        <= 1'b0;
            nvm_addr      <= `RBN_NVM_FIRST;
            nvm_wdata     <= 10'h000;
            cfg_addr      <= `RBN_NVM_FIRST;
            cfg_wr_en     <= 1'b0;
            cfg_wr_data   <= 10'h000;
        end
        else
        begin
            cfg_wr_en <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    save_timer <= 28'h000_0000;
                    if (start_save)
                    begin
                        state         <= ST_WRITE;
                        nvm_save_ctrl <= `RBN_SAV_START;
                        nvm_addr      <= `RBN_NVM_FIRST;
                        cfg_addr      <= `RBN_NVM_FIRST;
                    end
                    else if (wr_ok & hit_save)
                        nvm_save_ctrl <= pwdata[1:0];
                end
                ST_LOAD:
                begin
                    if (nvm_done)
                    begin
                        cfg_wr_en   <= (nvm_addr != `RBN_NVM_DEMAND_REG);
                        cfg_wr_data <= nvm_rdata;
                        cfg_addr    <= nvm_addr;
                        if (last_addr)
                        begin
                            state   <= ST_IDLE;
                            nvm_req <= 1'b0;
                        end
                        else
                            nvm_addr <= next_addr(nvm_addr);
                    end
                end
                ST_WRITE, ST_VERIFY:
                begin
                    save_timer <= save_timer + 28'h000_0001;
                    if (vpp_abort | limit_abort | (nvm_done & nvm_err))
                    begin
                        state         <= ST_IDLE;
                        nvm_req       <= 1'b0;
                        nvm_we        <= 1'b0;
                        nvm_save_ctrl <= `RBN_SAV_FAIL;
                    end
                    else if (!nvm_req)
                    begin
                        nvm_req   <= 1'b1;
                        nvm_we    <= state[2];
                        nvm_wdata <= expect_word;
                    end
                    else if (nvm_ack)
                    begin
                        nvm_req <= 1'b0;
                        if (state[3] && (nvm_rdata != expect_word))
                        begin
                            state         <= ST_IDLE;
                            nvm_we        <= 1'b0;
                            nvm_save_ctrl <= `RBN_SAV_FAIL;
                        end
                        else if (last_addr)
                        begin
                            nvm_addr <= `RBN_NVM_FIRST;
                            cfg_addr <= `RBN_NVM_FIRST;
                            nvm_we   <= 1'b0;
                            if (state[2])
                                state <= ST_VERIFY;
                            else
                            begin
                                state         <= ST_IDLE;
                                nvm_save_ctrl <= `RBN_SAV_ARMED;
                            end
                        end
                        else
                        begin
                            nvm_addr <= next_addr(nvm_addr);
                            cfg_addr <= next_addr(nvm_addr);
                        end
                    end
                end
                default:
                begin
                    state   <= ST_IDLE;
                    nvm_req <= 1'b0;
                end
            endcase
        end
    end

endmodule // rbn_readback_nvm

`default_nettype wire

/* verilog/rbn_map.vh */
`ifndef RBN_MAP_VH
`define RBN_MAP_VH

// Register byte offsets on the APB.
`define RBN_ADDR_CTRL       12'h000
`define RBN_ADDR_SAVE       12'h004
`define RBN_ADDR_DEMAND     12'h008
`define RBN_ADDR_READBACK   12'h00C
`define RBN_ADDR_STATUS     12'h010

// Control register fields.
`define RBN_CTRL_SEL_LSB    0
`define RBN_CTRL_KEEP_BIT   3
`define RBN_CTRL_AMODE_BIT  4
`define RBN_CTRL_SRES_LSB   5

// Readback select codes.
`define RBN_SEL_DIAG        3'h0
`define RBN_SEL_SPEED       3'h1
`define RBN_SEL_CURRENT     3'h2
`define RBN_SEL_SUPPLY      3'h3
`define RBN_SEL_TEMP        3'h4
`define RBN_SEL_DEMAND      3'h5
`define RBN_SEL_DUTY        3'h6
`define RBN_SEL_ADVANCE     3'h7

// Save control codes.
`define RBN_SAV_FAIL        2'h0
`define RBN_SAV_ARMED       2'h1
`define RBN_SAV_START       2'h2
`define RBN_SAV_BUSY_BIT    2

// Saved register window.
`define RBN_NVM_FIRST       5'h00
`define RBN_NVM_GAP_BEFORE  5'h17
`define RBN_NVM_GAP_AFTER   5'h19
`define RBN_NVM_SLEEP_REG   5'h1B
`define RBN_NVM_SLEEP_BIT   7
`define RBN_NVM_DEMAND_REG  5'h1E

// Reset values.
`define RBN_CTRL_RESET      8'h00
`define RBN_DEMAND_RESET    10'h000
`define RBN_SAVE_RESET      2'h1

// Timing.
`define RBN_CLK_MHZ         200
`define RBN_REFRESH_US      2000
`define RBN_REFRESH_CYC     (`RBN_REFRESH_US * `RBN_CLK_MHZ)
`define RBN_SAVE_MS         400
`define RBN_SAVE_LIMIT_CYC  (`RBN_SAVE_MS * 2 * 1000 * `RBN_CLK_MHZ)

`endif

/* verif/rbn_readback_nvm_props.sv */
`timescale 1ns/1ps
`default_nettype none
module rbn_readback_nvm_props (
    // APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Block side
    input wire logic        prog_voltage_low,
    input wire logic [2:0]  speed_resolution_sel,
    input wire logic        advance_mode_sel,
    input wire logic [9:0]  demand_value_out,
    input wire logic        cfg_wr_en,
    input wire logic        nvm_req,
    input wire logic        nvm_we,
    input wire logic        nvm_ack,
    input wire logic [4:0]  nvm_addr,
    input wire logic [9:0]  nvm_wdata,
    input wire logic        save_busy,
    input wire logic        load_busy,
    input wire logic [15:0] status_word
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc     = psel && penable;
    wire idle_wr = acc && pwrite && !save_busy && !load_busy;
    wire start   = idle_wr && paddr == 12'h004 && pwdata[1:0] == 2'b10;
    wire nvm_wr  = nvm_req && nvm_we;
    sequence s_abort;
        !save_busy && status_word[3] && status_word[15];
    endsequence
    sequence s_err_flags;
        status_word[13] && status_word[15];
    endsequence
    AST_BUSY_WR_REFUSED: assert property (acc && pwrite && save_busy |-> pslverr)
        else $error("write during save was accepted");
    AST_BUSY_WR_FLAGS: assert property (acc && pwrite && save_busy |=> s_err_flags)
        else $error("write during save left error flags clear");
    AST_SAVE_START: assert property ($rose(save_busy) |-> $past(start) || $past(start, 2))
        else $error("save began without a start write");
    AST_ABORT: assert property (save_busy && prog_voltage_low |-> ##[1:2] s_abort)
        else $error("programming undervoltage did not abort the save");
    AST_SKIP_CTRL_REG: assert property (nvm_wr |-> nvm_addr != 5'h18 && nvm_addr <= 5'h1E)
        else $error("save wrote an address outside the window");
    AST_SLEEP_NOT_SAVED: assert property (nvm_wr && nvm_addr == 5'h1B |-> !nvm_wdata[7])
        else $error("sleep request bit was saved");
    AST_DEMAND_SLICE: assert property (nvm_wr && nvm_addr == 5'h1E
        |-> nvm_wdata == {demand_value_out[9:2], 2'b00})
        else $error("demand slice saved wrongly");
    AST_READBACK_FRAME: assert property (acc && !pwrite && paddr == 12'h00C
        |-> ^prdata[15:0] && prdata[31:16] == 16'h0000)
        else $error("readback frame parity or padding wrong");
    AST_DEMAND_WR: assert property (idle_wr && paddr == 12'h008
        |=> demand_value_out == $past(pwdata[9:0]))
        else $error("demand readback does not follow the write");
    AST_CTRL_WR: assert property (idle_wr && paddr == 12'h000
        |=> speed_resolution_sel == $past(pwdata[7:5]))
        else $error("speed resolution does not follow the write");
    AST_RELOAD: assert property (nvm_ack && load_busy && nvm_addr < 5'h1E |-> ##[0:2] cfg_wr_en)
        else $error("reloaded word not written to registers");
endmodule // rbn_readback_nvm_props
bind rbn_readback_nvm rbn_readback_nvm_props u_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
    .prog_voltage_low, .speed_resolution_sel, .advance_mode_sel, .demand_value_out,
    .cfg_wr_en, .nvm_req, .nvm_we, .nvm_ack, .nvm_addr, .nvm_wdata,
    .save_busy, .load_busy, .status_word
);
`default_nettype wire

/* verif/rbn_nvm_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rbn_nvm_model (
    // Clock, reset and bench controls
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] dly,
    input  wire logic       bad,
    // Memory macro
    input  wire logic       nvm_req,
    input  wire logic       nvm_we,
    input  wire logic [4:0] nvm_addr,
    input  wire logic [9:0] nvm_wdata,
    output logic            nvm_ack,
    output logic            nvm_err,
    output logic [9:0]      nvm_rdata,
    // Configuration register file
    input  wire logic [4:0] cfg_addr,
    output logic [9:0]      cfg_rd_data,
    input  wire logic       cfg_wr_en,
    input  wire logic [9:0] cfg_wr_data
);
    logic [9:0] mem [32];
    logic [9:0] cfg [32];
    logic [9:0] rq;
    logic       eq;
    logic [3:0] cnt;
    // Outside an acknowledge the answer lines show junk, so a late sample cannot pass.
    assign nvm_rdata   = nvm_ack ? rq : ~rq;
    assign nvm_err     = nvm_ack ? eq : ~eq;
    assign cfg_rd_data = cfg[cfg_addr];
    initial
    begin
        for (int i = 0; i < 32; i++)
            mem[i] = 10'(i * 37 + 5);
        mem[30] = 10'h2A4;
    end
    always @(posedge pclk)
        if (cfg_wr_en)
            cfg[cfg_addr] <= cfg_wr_data;
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            nvm_ack <= 1'b0;
            cnt     <= 4'h0;
        end
        else if (nvm_ack || !nvm_req)
        begin
            nvm_ack <= 1'b0;
            cnt     <= 4'h0;
        end
        else if (cnt < dly)
            cnt <= cnt + 4'h1;
        else
        begin
            nvm_ack <= 1'b1;
            eq      <= bad;
            rq      <= mem[nvm_addr];
            if (nvm_we && !bad)
                mem[nvm_addr] <= nvm_wdata;
        end
endmodule // rbn_nvm_model
`default_nettype wire

/* verif/readback_mux_and_nvm_save_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module readback_mux_and_nvm_save_bench;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic        pready, pslverr, e, speed_strobe = 0, pwm_period_strobe = 0;
    logic [10:0] speed_count = 0;
    logic [9:0]  current_count = 0, supply_count = 0, temp_count = 0, duty_count = 0;
    logic [9:0]  advance_count = 0, pwm_demand = 0, demand_value_out, cfg_rd_data;
    logic [9:0]  cfg_wr_data, nvm_wdata, nvm_rdata;
    logic [8:0]  fault_in = 0, diag_in = 0;
    logic        meas_current = 1, pwm_demand_valid = 0, serial_write_attempt = 0;
    logic        prog_voltage_low = 0, bad = 0, advance_mode_sel, cfg_wr_en, nvm_req;
    logic        nvm_we, nvm_ack, nvm_err, save_busy, load_busy;
    logic [3:0]  dly = 4'h1;
    logic [2:0]  speed_resolution_sel;
    logic [4:0]  cfg_addr, nvm_addr;
    logic [15:0] status_word;
    logic [9:0]  rb [9] = '{10'h200, 10'h0D3, 10'h155, 10'h2AA, 10'h0F0, 10'h1C5,
                            10'h3FF, 10'h03F, 10'h07F};
    int          err_count = 0, tests_run = 0;
    rbn_readback_nvm #(.REFRESH_CYC(19'd20), .SAVE_LIMIT_CYC(28'd5000)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .speed_strobe, .speed_count, .meas_current, .current_count,
        .supply_count, .temp_count, .pwm_period_strobe, .duty_count, .advance_count,
        .pwm_demand_valid, .pwm_demand, .speed_resolution_sel, .advance_mode_sel,
        .demand_value_out, .fault_in, .diag_in, .serial_write_attempt, .prog_voltage_low,
        .cfg_addr, .cfg_rd_data, .cfg_wr_en, .cfg_wr_data, .nvm_req, .nvm_we, .nvm_addr,
        .nvm_wdata, .nvm_ack, .nvm_err, .nvm_rdata, .save_busy, .load_busy, .status_word);
    rbn_nvm_model u_nvm (.pclk, .presetn, .dly, .bad, .nvm_req, .nvm_we, .nvm_addr,
        .nvm_wdata, .nvm_ack, .nvm_err, .nvm_rdata, .cfg_addr, .cfg_rd_data, .cfg_wr_en,
        .cfg_wr_data);
    always #2.5 pclk = ~pclk;
    function automatic logic [9:0] seed(input int i);
        return 10'(i * 37 + 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        tests_run++;
        if (got !== ex)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        logic r;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do
        begin
            // Inputs move only at rising edges, so the falling edge shows what the next samples.
            @(negedge pclk);
            r = pready;
            q = prdata;
            e = pslverr;
            @(posedge pclk);
            n++;
        end
        while (r !== 1'b1 && n < 50);
        if (r !== 1'b1)
            err_count++;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic x);
        apb(1, a, d);
        chk("pslverr", 32'(x), 32'(e));
    endtask
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 0);
        chk(nm, x, q);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do
            @(negedge pclk);
        while ((save_busy | load_busy) !== 1'b0 && ++n < 3000);
        chk("busy", 0, 32'({save_busy, load_busy}));
    endtask
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #100000;
        err_count++;
        wrap_up;
    end
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        wr(12'h000, 32'h0000_0001, 1);
        rd("status", 12'h010, 32'h0000_C000);
        rd("status", 12'h010, 32'h0000_0000);
        wait_idle;
        for (int i = 0; i < 30; i++)
            if (i != 24)
                chk("reload", 32'(seed(i)), 32'(u_nvm.cfg[i]));
        rd("demand", 12'h008, 32'h0000_02A4);
        speed_count <= 11'h4D3;
        current_count <= 10'h155;
        supply_count <= 10'h2AA;
        temp_count <= 10'h0F0;
        duty_count <= 10'h3FF;
        advance_count <= 10'h07F;
        speed_strobe <= 1;
        pwm_period_strobe <= 1;
        pwm_demand <= 10'h0AB;
        pwm_demand_valid <= 1;
        @(posedge pclk);
        speed_strobe <= 0;
        pwm_period_strobe <= 0;
        pwm_demand_valid <= 0;
        repeat (25) @(posedge pclk);
        rd("demand", 12'h008, 32'h0000_00AB);
        wr(12'h008, 32'h0000_01C5, 0);
        for (int s = 0; s < 9; s++)
        begin
            wr(12'h000, {27'h0, s == 8, 1'b0, 3'(s > 7 ? 7 : s)}, 0);
            rd("readback", 12'h00C, {16'h0, 5'h00, rb[s], ~^rb[s]});
        end
        for (int k = 0; k < 3; k++)
            wr(12'h00C + 12'(k * 4), 32'h0, 1);
        fault_in <= 9'h001;
        @(posedge pclk);
        fault_in <= 9'h000;
        wr(12'h000, 32'h0000_0008, 0);
        rd("status", 12'h010, 32'h0000_8010);
        rd("status", 12'h010, 32'h0000_8010);
        wr(12'h000, 32'h0000_0000, 0);
        rd("status", 12'h010, 32'h0000_8010);
        rd("status", 12'h010, 32'h0000_0000);
        for (int i = 0; i < 30; i++)
            u_nvm.cfg[i] = seed(i) ^ 10'h155;
        dly <= 4'h6;
        wr(12'h004, 32'h0000_0002, 0);
        rd("save", 12'h004, 32'h0000_0006);
        wr(12'h008, 32'h0000_0011, 1);
        wr(12'h004, 32'h0000_0002, 1);
        rd("status", 12'h010, 32'h0000_A000);
        serial_write_attempt <= 1;
        @(posedge pclk);
        serial_write_attempt <= 0;
        rd("status", 12'h010, 32'h0000_A000);
        wait_idle;
        rd("save", 12'h004, 32'h0000_0001);
        for (int i = 0; i < 30; i++)
            if (i != 24)
                chk("saved", 32'((seed(i) ^ 10'h155) & (i == 27 ? 10'h37F : 10'h3FF)),
                    32'(u_nvm.mem[i]));
        chk("saved", 32'h0000_01C4, 32'(u_nvm.mem[30]));
        bad <= 1;
        wr(12'h004, 32'h0000_0002, 0);
        wait_idle;
        bad <= 0;
        rd("save", 12'h004, 32'h0000_0000);
        apb(0, 12'h010, 0);
        wr(12'h004, 32'h0000_0001, 0);
        wr(12'h004, 32'h0000_0002, 0);
        repeat (20) @(posedge pclk);
        prog_voltage_low <= 1;
        repeat (2) @(posedge pclk);
        prog_voltage_low <= 0;
        chk("busy", 0, 32'(save_busy));
        rd("save", 12'h004, 32'h0000_0000);
        rd("status", 12'h010, 32'h0000_8008);
        wrap_up;
    end
endmodule // readback_mux_and_nvm_save_bench
`default_nettype wire
